// ==== src/switchgear_object_control.sv ====
// switching object control and monitoring with an AXI4-Lite register slave
// What this block does
// - separate open and close command outputs
// - position from open and closed inputs
// - optional single input, inverted for open
// - local, remote and automatic command sources
// - remote direct or select-before-execute
// - report commands, position and applied operations
// - configuration changes only by software writes
// - status, blocking, ready, sync, cart inputs
// - time-stamped events on command edges
// - clearable operation and failure counters
// - control logic, monitor, output handler stages
// - position codes intermediate, open, closed, bad
// - local/remote selector ignores other side
// - close only with sync when enabled
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module switchgear_object_control
	import switchgear_object_control_pkg::*;
#(
	parameter int MS_CYCLES = CYCLES_PER_MS,
	parameter int COUNT_W = 32,
	parameter int EVENT_ADDR_W = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_enable,
	input wire pins_t i_pins,
	input wire logic i_auto_open,
	input wire logic i_auto_close,
	input wire axil_req_t i_axi,
	output axil_rsp_t o_axi,
	output logic o_open_cmd,
	output logic o_close_cmd,
	output logic [1:0] o_position,
	output logic [2:0] o_cart_status
);
	typedef struct packed {
		op_state_t op;
		logic open_out;
		logic close_out;
		logic selected;
		logic [CFG_W-1:0] cfg;
		logic [TIMEOUT_W-1:0] timeout_ms;
		logic [TIMEOUT_W-1:0] op_ms;
		logic [STAMP_W-1:0] now_ms;
		logic [31:0] tick;
		logic [3:0][COUNT_W-1:0] count;
		logic [1:0] pos;
		logic [2:0] cart;
		logic [1:0] last_local;
		logic overflow;
		logic [EVENT_ADDR_W:0] wr_ptr;
		logic [EVENT_ADDR_W:0] rd_ptr;
		logic aw_held;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic w_held;
		logic [AXI_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic r_stage;
		logic [AXI_ADDR_W-1:0] araddr;
		logic rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} ctl_t;

	ctl_t s;
	ctl_t next_s;
	logic [PIN_W-1:0] sync_a;
	logic [PIN_W-1:0] sync_b;
	pins_t pin;
	logic ev_write;
	logic [AXI_DATA_W-1:0] ev_word;
	logic [AXI_DATA_W-1:0] ev_head;

	// two-stage synchronisers for every pin input
	genvar g;
	generate
		for (g = 0; g < PIN_W; g++)
		begin : g_sync
			always_ff @(posedge i_clock or posedge i_rst)
			begin
				if (i_rst)
				begin
					sync_a[g] <= 1'b0;
					sync_b[g] <= 1'b0;
				end
				else if (i_enable)
				begin
					sync_a[g] <= i_pins[g];
					sync_b[g] <= sync_a[g];
				end
			end
		end
	endgenerate

	assign pin = pins_t'(sync_b);

	function automatic logic [1:0] decode_pos(input logic single, input logic op_in,
		input logic cl_in);
		// {closed, open}: 00 intermediate, 01 open, 10 closed, 11 bad
		if (single)
			decode_pos = {cl_in, ~cl_in};
		else
			decode_pos = {cl_in, op_in};
	endfunction : decode_pos

	always_comb
	begin
		logic do_write;
		logic remote;
		logic sbo;
		logic cmd_open;
		logic cmd_close;
		logic cmd_sel;
		logic cmd_desel;
		logic cmd_clear;
		logic cmd_pop;
		logic req_open;
		logic req_close;
		logic rem_open;
		logic rem_close;
		logic ms_tick;
		logic timed_out;
		logic empty;
		logic full;
		logic [3:0] inc;
		logic [EV_FLAGS_W-1:0] flags;
		logic [AXI_DATA_W-1:0] rd_value;
		logic rd_ok;
		do_write = 1'b0;
		remote = s.cfg[CFG_REMOTE];
		sbo = s.cfg[CFG_SELECT_FIRST];
		cmd_open = 1'b0;
		cmd_close = 1'b0;
		cmd_sel = 1'b0;
		cmd_desel = 1'b0;
		cmd_clear = 1'b0;
		cmd_pop = 1'b0;
		inc = 4'h0;
		flags = '0;
		rd_value = '0;
		rd_ok = 1'b1;
		next_s = s;
		ev_write = 1'b0;
		ev_word = '0;
		rem_open = 1'b0;
		rem_close = 1'b0;
		req_open = 1'b0;
		req_close = 1'b0;
		timed_out = 1'b0;
		ms_tick = 1'b0;
		empty = 1'b0;
		full = 1'b0;

		// millisecond time base for stamps and timeouts
		ms_tick = (s.tick == 32'(MS_CYCLES - 1));
		next_s.tick = ms_tick ? 32'h0 : s.tick + 32'h1;
		next_s.now_ms = s.now_ms + STAMP_W'(ms_tick);
		empty = (s.wr_ptr == s.rd_ptr);
		full = (s.wr_ptr[EVENT_ADDR_W] != s.rd_ptr[EVENT_ADDR_W]) &&
			(s.wr_ptr[EVENT_ADDR_W-1:0] == s.rd_ptr[EVENT_ADDR_W-1:0]);

		// write channel: address and data taken in either order
		if (i_axi.awvalid && s.awready)
		begin
			next_s.aw_held = 1'b1;
			next_s.awaddr = i_axi.awaddr;
		end
		if (i_axi.wvalid && s.wready)
		begin
			next_s.w_held = 1'b1;
			next_s.wdata = i_axi.wdata;
			next_s.wstrb = i_axi.wstrb;
		end
		if (s.bvalid && i_axi.bready)
			next_s.bvalid = 1'b0;
		do_write = s.aw_held && s.w_held && !s.bvalid;
		if (do_write)
		begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.awaddr)
				REG_CONFIG:
					if (s.wstrb[0])
						next_s.cfg = s.wdata[CFG_W-1:0];
				REG_TIMEOUT:
				begin
					if (s.wstrb[0])
						next_s.timeout_ms[7:0] = s.wdata[7:0];
					if (s.wstrb[1])
						next_s.timeout_ms[15:8] = s.wdata[15:8];
				end
				REG_COMMAND:
					if (s.wstrb[0])
					begin
						cmd_sel = s.wdata[CMD_SELECT];
						cmd_desel = s.wdata[CMD_DESELECT];
						cmd_open = s.wdata[CMD_OPEN];
						cmd_close = s.wdata[CMD_CLOSE];
						cmd_clear = s.wdata[CMD_CLEAR_COUNTS];
						cmd_pop = s.wdata[CMD_POP_EVENT];
					end
				REG_STATUS, REG_OPEN_COUNT, REG_CLOSE_COUNT, REG_TRIP_FAILURE_COUNT,
				REG_MAKE_FAILURE_COUNT, REG_EVENT:
					next_s.bresp = RESP_OKAY;
				default:
					next_s.bresp = RESP_SLVERR;
			endcase
		end

		// control logic: pick the source allowed by the selector
		rem_open = cmd_open && remote && (!sbo || s.selected);
		rem_close = cmd_close && remote && (!sbo || s.selected);
		req_open = rem_open || i_auto_open ||
			(!remote && pin.local_open && !s.last_local[0]);
		req_close = rem_close || i_auto_close ||
			(!remote && pin.local_close && !s.last_local[1]);
		next_s.last_local = {pin.local_close, pin.local_open};
		if (cmd_sel && remote && sbo)
			next_s.selected = 1'b1;
		if (cmd_desel || !remote || rem_open || rem_close)
			next_s.selected = 1'b0;

		// monitor: supervise the running operation
		next_s.pos = decode_pos(s.cfg[CFG_SINGLE_INPUT], pin.status_open, pin.status_closed);
		next_s.cart = s.cfg[CFG_WITHDRAWABLE] ? {1'b0, pin.cart_in, pin.cart_out} :
			CART_NOT_USED;
		if (ms_tick)
			next_s.op_ms = s.op_ms + TIMEOUT_W'(1);
		timed_out = ms_tick && (s.op_ms >= s.timeout_ms);
		case (s.op)
			OP_IDLE:
			begin
				next_s.op_ms = '0;
				// open wins over a simultaneous close: the safe direction
				if (req_open)
				begin
					if (pin.block_open)
						flags[EV_REFUSED] = 1'b1;
					else
						next_s.op = OP_OPENING;
				end
				else if (req_close)
				begin
					if (pin.block_close || !pin.ready ||
						(s.cfg[CFG_SYNC_USE] && !pin.sync_ok))
						flags[EV_REFUSED] = 1'b1;
					else
						next_s.op = OP_CLOSING;
				end
			end
			OP_OPENING:
			begin
				if (s.pos == POS_OPEN)
				begin
					inc[CNT_OPEN] = 1'b1;
					next_s.op = OP_IDLE;
				end
				else if (pin.block_open)
				begin
					flags[EV_REFUSED] = 1'b1;
					next_s.op = OP_IDLE;
				end
				else if (timed_out)
				begin
					inc[CNT_TRIP_FAILURE] = 1'b1;
					flags[EV_TRIP_FAILURE] = 1'b1;
					next_s.op = OP_IDLE;
				end
			end
			OP_CLOSING:
			begin
				if (s.pos == POS_CLOSED)
				begin
					inc[CNT_CLOSE] = 1'b1;
					next_s.op = OP_IDLE;
				end
				else if (pin.block_close || (s.cfg[CFG_SYNC_USE] && !pin.sync_ok))
				begin
					flags[EV_REFUSED] = 1'b1;
					next_s.op = OP_IDLE;
				end
				else if (timed_out)
				begin
					inc[CNT_MAKE_FAILURE] = 1'b1;
					flags[EV_MAKE_FAILURE] = 1'b1;
					next_s.op = OP_IDLE;
				end
			end
			default:
				next_s.op = OP_IDLE;
		endcase

		// output handler: one state drives one contact only
		next_s.open_out = (next_s.op == OP_OPENING);
		next_s.close_out = (next_s.op == OP_CLOSING);

		// counters: an increment in the clearing cycle still counts
		for (int i = 0; i < 4; i++)
			next_s.count[i] = (cmd_clear ? '0 : s.count[i]) + COUNT_W'(inc[i]);

		// events on each command edge and position change
		flags[EV_OPEN_ON] = next_s.open_out && !s.open_out;
		flags[EV_OPEN_OFF] = !next_s.open_out && s.open_out;
		flags[EV_CLOSE_ON] = next_s.close_out && !s.close_out;
		flags[EV_CLOSE_OFF] = !next_s.close_out && s.close_out;
		flags[EV_POS_CHANGE] = (next_s.pos != s.pos);
		if (cmd_pop)
			next_s.overflow = 1'b0;
		if (cmd_pop && !empty)
			next_s.rd_ptr = s.rd_ptr + (EVENT_ADDR_W+1)'(1);
		if (|flags)
		begin
			// a full buffer with no pop in the same cycle drops the new event and flags it
			if (full && !(cmd_pop && !empty))
				next_s.overflow = 1'b1;
			else
			begin
				ev_write = 1'b1;
				ev_word = {s.now_ms, 6'h00, next_s.pos, flags};
				next_s.wr_ptr = s.wr_ptr + (EVENT_ADDR_W+1)'(1);
			end
		end

		// read channel: two cycles so the event memory output has settled
		if (s.rvalid && i_axi.rready)
			next_s.rvalid = 1'b0;
		if (i_axi.arvalid && s.arready)
		begin
			next_s.r_stage = 1'b1;
			next_s.araddr = i_axi.araddr;
		end
		case (s.araddr)
			REG_CONFIG: rd_value = AXI_DATA_W'(s.cfg);
			REG_TIMEOUT: rd_value = AXI_DATA_W'(s.timeout_ms);
			REG_COMMAND: rd_value = '0;
			REG_STATUS:
			begin
				rd_value[ST_POS_LSB +: 2] = s.pos;
				rd_value[ST_CART_LSB +: 3] = s.cart;
				rd_value[ST_OPEN_OUT] = s.open_out;
				rd_value[ST_CLOSE_OUT] = s.close_out;
				rd_value[ST_SELECTED] = s.selected;
				rd_value[ST_EVENT_AVAIL] = !empty;
				rd_value[ST_OVERFLOW] = s.overflow;
			end
			REG_OPEN_COUNT: rd_value = AXI_DATA_W'(s.count[CNT_OPEN]);
			REG_CLOSE_COUNT: rd_value = AXI_DATA_W'(s.count[CNT_CLOSE]);
			REG_TRIP_FAILURE_COUNT: rd_value = AXI_DATA_W'(s.count[CNT_TRIP_FAILURE]);
			REG_MAKE_FAILURE_COUNT: rd_value = AXI_DATA_W'(s.count[CNT_MAKE_FAILURE]);
			REG_EVENT: rd_value = empty ? '0 : ev_head;
			default: rd_ok = 1'b0;
		endcase
		if (s.r_stage)
		begin
			next_s.r_stage = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_ok ? rd_value : '0;
			next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready = !next_s.w_held && !next_s.bvalid;
		next_s.arready = !next_s.r_stage && !next_s.rvalid;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			s <= '0;
			s.op <= OP_IDLE;
			s.cfg <= CFG_RESET;
			s.timeout_ms <= TIMEOUT_RESET;
		end
		else if (i_enable)
			s <= next_s;
	end

	event_store #(
		.ADDR_W(EVENT_ADDR_W),
		.DATA_W(AXI_DATA_W)
	) u_event_store (
		.i_clock(i_clock),
		.i_enable(i_enable),
		.i_write(ev_write),
		.i_write_addr(s.wr_ptr[EVENT_ADDR_W-1:0]),
		.i_write_data(ev_word),
		.i_read_addr(s.rd_ptr[EVENT_ADDR_W-1:0]),
		.o_read_data(ev_head)
	);

	assign o_open_cmd = s.open_out;
	assign o_close_cmd = s.close_out;
	assign o_position = s.pos;
	assign o_cart_status = s.cart;
	assign o_axi.awready = s.awready;
	assign o_axi.wready = s.wready;
	assign o_axi.bvalid = s.bvalid;
	assign o_axi.bresp = s.bresp;
	assign o_axi.arready = s.arready;
	assign o_axi.rvalid = s.rvalid;
	assign o_axi.rdata = s.rdata;
	assign o_axi.rresp = s.rresp;
endmodule : switchgear_object_control

// ==== src/switchgear_object_control_pkg.sv ====
// shared constants, register map and carrier types for the switchgear object control
package switchgear_object_control_pkg;

	// timing
	localparam int CLOCK_HZ = 10_000_000;
	localparam int EVENT_RES_MS = 1;
	localparam int CYCLES_PER_MS = CLOCK_HZ / 1000 * EVENT_RES_MS;

	// bus shape
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register byte offsets
	localparam logic [AXI_ADDR_W-1:0] REG_CONFIG = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] REG_COMMAND = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] REG_OPEN_COUNT = 8'h0C;
	localparam logic [AXI_ADDR_W-1:0] REG_CLOSE_COUNT = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] REG_TRIP_FAILURE_COUNT = 8'h14;
	localparam logic [AXI_ADDR_W-1:0] REG_MAKE_FAILURE_COUNT = 8'h18;
	localparam logic [AXI_ADDR_W-1:0] REG_EVENT = 8'h1C;
	localparam logic [AXI_ADDR_W-1:0] REG_TIMEOUT = 8'h20;

	// configuration fields
	localparam int CFG_W = 5;
	localparam int CFG_SINGLE_INPUT = 0;
	localparam int CFG_SELECT_FIRST = 1;
	localparam int CFG_SYNC_USE = 2;
	localparam int CFG_REMOTE = 3;
	localparam int CFG_WITHDRAWABLE = 4;
	localparam logic [CFG_W-1:0] CFG_RESET = 5'h08;
	localparam int TIMEOUT_W = 16;
	localparam logic [TIMEOUT_W-1:0] TIMEOUT_RESET = 16'h00C8;

	// command fields, write-only pulses
	localparam int CMD_SELECT = 0;
	localparam int CMD_DESELECT = 1;
	localparam int CMD_OPEN = 2;
	localparam int CMD_CLOSE = 3;
	localparam int CMD_CLEAR_COUNTS = 4;
	localparam int CMD_POP_EVENT = 5;

	// status fields
	localparam int ST_POS_LSB = 0;
	localparam int ST_CART_LSB = 2;
	localparam int ST_OPEN_OUT = 5;
	localparam int ST_CLOSE_OUT = 6;
	localparam int ST_SELECTED = 7;
	localparam int ST_EVENT_AVAIL = 8;
	localparam int ST_OVERFLOW = 9;

	// position and cart codes
	localparam logic [1:0] POS_INTERMEDIATE = 2'h0;
	localparam logic [1:0] POS_OPEN = 2'h1;
	localparam logic [1:0] POS_CLOSED = 2'h2;
	localparam logic [1:0] POS_BAD = 2'h3;
	localparam logic [2:0] CART_NOT_USED = 3'h4;

	// event word: [31:16] ms stamp, [9:8] position, [7:0] flags
	localparam int EV_FLAGS_W = 8;
	localparam int EV_OPEN_ON = 0;
	localparam int EV_OPEN_OFF = 1;
	localparam int EV_CLOSE_ON = 2;
	localparam int EV_CLOSE_OFF = 3;
	localparam int EV_TRIP_FAILURE = 4;
	localparam int EV_MAKE_FAILURE = 5;
	localparam int EV_REFUSED = 6;
	localparam int EV_POS_CHANGE = 7;
	localparam int STAMP_W = 16;

	// counter indices
	localparam int CNT_OPEN = 0;
	localparam int CNT_CLOSE = 1;
	localparam int CNT_TRIP_FAILURE = 2;
	localparam int CNT_MAKE_FAILURE = 3;

	typedef struct packed {
		logic awvalid;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [AXI_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_ADDR_W-1:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic local_close;
		logic local_open;
		logic cart_out;
		logic cart_in;
		logic sync_ok;
		logic ready;
		logic block_close;
		logic block_open;
		logic status_closed;
		logic status_open;
	} pins_t;

	localparam int PIN_W = $bits(pins_t);

	typedef enum logic [1:0] {OP_IDLE, OP_OPENING, OP_CLOSING} op_state_t;

endpackage : switchgear_object_control_pkg

// ==== src/event_store.sv ====
// small event memory with registered read data
`timescale 1ns/100ps
module event_store #(
	parameter int ADDR_W = 4,
	parameter int DATA_W = 32
) (
	input wire logic i_clock,
	input wire logic i_enable,
	input wire logic i_write,
	input wire logic [ADDR_W-1:0] i_write_addr,
	input wire logic [DATA_W-1:0] i_write_data,
	input wire logic [ADDR_W-1:0] i_read_addr,
	output logic [DATA_W-1:0] o_read_data
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// no reset on the array: contents are only read behind a valid pointer
	always_ff @(posedge i_clock)
	begin
		if (i_enable)
		begin
			if (i_write)
				mem[i_write_addr] <= i_write_data;
			o_read_data <= mem[i_read_addr];
		end
	end
endmodule : event_store

// ==== verif/breaker_model.sv ====
// breaker model answering the open and close contacts with its two position outputs
`timescale 1ns/100ps
module breaker_model #(
	parameter int TRAVEL = 4
) (
	input wire logic i_clock,
	input wire logic i_open_cmd,
	input wire logic i_close_cmd,
	input wire logic i_stuck,
	output logic o_status_open,
	output logic o_status_closed
);
	int t;
	initial
	begin
		t = 0;
		o_status_open = 1'b0;
		o_status_closed = 1'b1;
	end
	// one contact per direction, two position lines back
	always @(posedge i_clock)
	begin
		if (i_stuck || !(i_open_cmd || i_close_cmd))
			t <= 0;
		else
		begin
			t <= t + 1;
			// mid travel neither line is active
			if (t == 0)
				{o_status_open, o_status_closed} <= 2'b00;
			if (t == TRAVEL)
				{o_status_open, o_status_closed} <= {i_open_cmd, !i_open_cmd};
		end
	end
endmodule : breaker_model

// ==== verif/switchgear_object_control_chk.sv ====
// port-level assertions for the object control block
`timescale 1ns/100ps
module switchgear_object_control_chk
	import switchgear_object_control_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire pins_t i_pins,
	input wire axil_req_t i_axi,
	input wire axil_rsp_t o_axi,
	input wire logic o_open_cmd,
	input wire logic o_close_cmd,
	input wire logic [1:0] o_position,
	input wire logic [2:0] o_cart_status
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// five samples cover two sync flops and the registered output
	a_no_both_cmds: assert property (!(o_open_cmd && o_close_cmd))
		else $error("both commands high");
	a_open_blocked: assert property (i_pins.block_open [*5] |-> !o_open_cmd)
		else $error("open while blocked");
	a_close_blocked: assert property (i_pins.block_close [*5] |-> !o_close_cmd)
		else $error("close while blocked");
	a_close_unready: assert property ((!i_pins.ready) [*5] |-> !o_close_cmd)
		else $error("close while not ready");
	a_pos_open: assert property ((i_pins.status_open && !i_pins.status_closed) [*5]
		|-> o_position == POS_OPEN)
		else $error("open position not shown");
	a_pos_closed: assert property ((!i_pins.status_open && i_pins.status_closed) [*5]
		|-> o_position == POS_CLOSED)
		else $error("closed position not shown");
	a_open_after_close: assert property ($rose(o_open_cmd) |-> !$past(o_close_cmd))
		else $error("open rose over close");
	a_read_latency: assert property (i_axi.arvalid && o_axi.arready |-> ##2 o_axi.rvalid)
		else $error("read answer late");
	a_bresp_stands: assert property (o_axi.bvalid && !i_axi.bready
		|=> o_axi.bvalid && $stable(o_axi.bresp))
		else $error("write response dropped");
	a_cart_range: assert property (o_cart_status <= CART_NOT_USED)
		else $error("cart code out of range");
endmodule : switchgear_object_control_chk
bind switchgear_object_control switchgear_object_control_chk i_switchgear_object_control_chk (
	.i_clock(i_clock), .i_rst(i_rst), .i_pins(i_pins), .i_axi(i_axi), .o_axi(o_axi),
	.o_open_cmd(o_open_cmd), .o_close_cmd(o_close_cmd), .o_position(o_position),
	.o_cart_status(o_cart_status));

// ==== verif/switchgear_object_control_test.sv ====
// self-checking bench for the object control block
`timescale 1ns/100ps
module switchgear_object_control_test;
	import switchgear_object_control_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	pins_t drv = '0;
	pins_t pins;
	logic auto_open = 1'b0;
	logic auto_close = 1'b0;
	logic stuck = 1'b0;
	axil_req_t req = '0;
	axil_rsp_t rsp;
	logic open_cmd, close_cmd, st_open, st_closed;
	logic [1:0] position;
	logic [2:0] cart;
	int fail_count = 0;
	int checked = 0;
	int cnt [4] = '{0, 0, 0, 0};
	logic [31:0] v, seed;
	logic [7:0] f;
	always #50 i_clock = !i_clock;
	assign pins = {drv[PIN_W-1:2], st_closed, st_open};
	switchgear_object_control #(.MS_CYCLES(10)) i_switchgear_object_control (.i_clock(i_clock),
		.i_rst(i_rst), .i_enable(1'b1), .i_pins(pins), .i_auto_open(auto_open),
		.i_auto_close(auto_close), .i_axi(req), .o_axi(rsp), .o_open_cmd(open_cmd),
		.o_close_cmd(close_cmd), .o_position(position), .o_cart_status(cart));
	breaker_model i_breaker_model (.i_clock(i_clock), .i_open_cmd(open_cmd),
		.i_close_cmd(close_cmd), .i_stuck(stuck), .o_status_open(st_open),
		.o_status_closed(st_closed));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, ta, tw;
		aw = 0;
		w = 0;
		@(posedge i_clock);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		while (!(aw && w))
		begin
			@(negedge i_clock);
			ta = req.awvalid && rsp.awready;
			tw = req.wvalid && rsp.wready;
			@(posedge i_clock);
			if (ta) begin aw = 1; req.awvalid <= 1'b0; end
			if (tw) begin w = 1; req.wvalid <= 1'b0; end
		end
		do @(negedge i_clock); while (rsp.bvalid !== 1'b1);
		chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
		@(posedge i_clock);
		req.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge i_clock);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do @(negedge i_clock); while (rsp.arready !== 1'b1);
		@(posedge i_clock);
		req.arvalid <= 1'b0;
		do @(negedge i_clock); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
		@(posedge i_clock);
		req.rready <= 1'b0;
	endtask : rd
	// refused requests are watched for 40 cycles, long past the answer latency
	task automatic op(input logic cl, input logic runs);
		logic s;
		s = 0;
		for (int i = 0; i < 40 && !(runs && s); i++)
		begin
			@(negedge i_clock);
			s = s | (cl ? close_cmd : open_cmd);
		end
		chk("command", {31'h0, s}, {31'h0, runs});
		while ((cl ? close_cmd : open_cmd) === 1'b1)
			@(negedge i_clock);
		repeat (5) @(negedge i_clock);
	endtask : op
	task automatic pulse(input logic cl);
		@(posedge i_clock);
		if (cl) auto_close <= 1'b1; else auto_open <= 1'b1;
		@(posedge i_clock);
		auto_close <= 1'b0;
		auto_open <= 1'b0;
	endtask : pulse
	task automatic drain(output logic [7:0] fl);
		logic [31:0] s, e;
		fl = 0;
		for (int i = 0; i < 20; i++)
		begin
			rd(REG_STATUS, s, RESP_OKAY);
			if (s[ST_EVENT_AVAIL] === 1'b1)
			begin
				rd(REG_EVENT, e, RESP_OKAY);
				fl = fl | e[7:0];
				wr(REG_COMMAND, 32'h1 << CMD_POP_EVENT, RESP_OKAY);
			end
		end
	endtask : drain
	task automatic counts();
		for (int k = 0; k < 4; k++)
		begin
			rd(REG_OPEN_COUNT + 8'(4 * k), v, RESP_OKAY);
			chk("count", v, cnt[k]);
		end
	endtask : counts
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#5_000_000;
		fail_count++;
		tally_and_finish();
	end
	initial
	begin
		seed = 32'h79E57A21;
		drv.ready = 1'b1;
		repeat (12) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clock);
		rd(REG_CONFIG, v, RESP_OKAY);
		chk("config reset", v, {27'h0, CFG_RESET});
		rd(REG_TIMEOUT, v, RESP_OKAY);
		chk("timeout reset", v, {16'h0, TIMEOUT_RESET});
		rd(8'h40, v, RESP_SLVERR);
		wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
		seed = lfsr(seed);
		wr(REG_TIMEOUT, seed, RESP_OKAY);
		rd(REG_TIMEOUT, v, RESP_OKAY);
		chk("timeout rw", v, {16'h0, seed[15:0]});
		wr(REG_TIMEOUT, {16'h0, TIMEOUT_RESET}, RESP_OKAY);
		chk("cart", {29'h0, cart}, {29'h0, CART_NOT_USED});
		$display("test 1 done");
		drain(f);
		wr(REG_COMMAND, 32'h1 << CMD_OPEN, RESP_OKAY);
		op(0, 1);
		cnt[CNT_OPEN]++;
		chk("position", {30'h0, position}, {30'h0, POS_OPEN});
		drain(f);
		chk("events", {24'h0, f & 8'h03}, 32'h3);
		wr(REG_COMMAND, 32'h1 << CMD_CLOSE, RESP_OKAY);
		op(1, 1);
		cnt[CNT_CLOSE]++;
		$display("test 2 done");
		wr(REG_CONFIG, 32'h0A, RESP_OKAY);
		wr(REG_COMMAND, 32'h1 << CMD_OPEN, RESP_OKAY);
		op(0, 0);
		wr(REG_COMMAND, 32'h1 << CMD_SELECT, RESP_OKAY);
		wr(REG_COMMAND, 32'h1 << CMD_DESELECT, RESP_OKAY);
		wr(REG_COMMAND, 32'h1 << CMD_OPEN, RESP_OKAY);
		op(0, 0);
		wr(REG_COMMAND, 32'h1 << CMD_SELECT, RESP_OKAY);
		wr(REG_COMMAND, 32'h1 << CMD_OPEN, RESP_OKAY);
		op(0, 1);
		cnt[CNT_OPEN]++;
		$display("test 3 done");
		wr(REG_CONFIG, 32'h00, RESP_OKAY);
		wr(REG_COMMAND, 32'h1 << CMD_CLOSE, RESP_OKAY);
		op(1, 0);
		@(posedge i_clock);
		drv.local_close <= 1'b1;
		repeat (4) @(posedge i_clock);
		drv.local_close <= 1'b0;
		op(1, 1);
		cnt[CNT_CLOSE]++;
		$display("test 4 done");
		@(posedge i_clock);
		drv.block_open <= 1'b1;
		repeat (4) @(posedge i_clock);
		pulse(0);
		op(0, 0);
		@(posedge i_clock);
		drv.block_open <= 1'b0;
		repeat (4) @(posedge i_clock);
		pulse(0);
		op(0, 1);
		cnt[CNT_OPEN]++;
		@(posedge i_clock);
		drv.block_close <= 1'b1;
		repeat (4) @(posedge i_clock);
		pulse(1);
		op(1, 0);
		@(posedge i_clock);
		drv.block_close <= 1'b0;
		wr(REG_CONFIG, 32'h04, RESP_OKAY);
		drv.ready <= 1'b0;
		drv.sync_ok <= 1'b1;
		repeat (4) @(posedge i_clock);
		pulse(1);
		op(1, 0);
		@(posedge i_clock);
		drv.ready <= 1'b1;
		drv.sync_ok <= 1'b0;
		repeat (4) @(posedge i_clock);
		pulse(1);
		op(1, 0);
		@(posedge i_clock);
		drv.sync_ok <= 1'b1;
		repeat (4) @(posedge i_clock);
		pulse(1);
		op(1, 1);
		cnt[CNT_CLOSE]++;
		$display("test 5 done");
		@(posedge i_clock);
		stuck <= 1'b1;
		wr(REG_TIMEOUT, 32'h2, RESP_OKAY);
		pulse(0);
		op(0, 1);
		cnt[CNT_TRIP_FAILURE]++;
		@(posedge i_clock);
		stuck <= 1'b0;
		wr(REG_CONFIG, 32'h01, RESP_OKAY);
		repeat (5) @(posedge i_clock);
		chk("single closed", {30'h0, position}, {30'h0, POS_CLOSED});
		wr(REG_TIMEOUT, {16'h0, TIMEOUT_RESET}, RESP_OKAY);
		pulse(0);
		op(0, 1);
		cnt[CNT_OPEN]++;
		chk("single open", {30'h0, position}, {30'h0, POS_OPEN});
		counts();
		wr(REG_COMMAND, 32'h1 << CMD_CLEAR_COUNTS, RESP_OKAY);
		cnt = '{0, 0, 0, 0};
		counts();
		wr(REG_CONFIG, 32'h10, RESP_OKAY);
		drv.cart_in <= 1'b1;
		repeat (5) @(posedge i_clock);
		@(negedge i_clock);
		chk("cart in", {29'h0, cart}, 32'h2);
		$display("test 6 done");
		tally_and_finish();
	end
endmodule : switchgear_object_control_test
